// file: src/dtpwm_core.sv
// Purpose: Programmable PWM with complementary outputs, dead-time and config lock
// Assumes: Register port on CLOCK; inhibit pin is asynchronous
// Notes:   Counter runs free; width changes land inside the current period
//
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/1ps
module dtpwm_core
    import dtpwm_pkg::*;
(
    // Clock and reset
    input  wire logic                 CLOCK,
    input  wire logic                 RST,
    // Register port
    input  wire dtpwm_pkg::reg_req_t  REG_REQ,
    output logic [7:0]                REG_RDATA,
    // Hardware inhibit, active low: low forces outputs off
    input  wire logic                 OUTPUT_ENABLE_N_INHIBIT,
    // Drive outputs
    output logic                      PRIMARY_DRIVE_OUT,
    output logic                      COMPLEMENTARY_DRIVE_OUT
);
    import dtpwm_pkg::*;

    typedef enum logic {RUN_OFF, RUN_ON} run_state_t;

    // Registers
    logic [7:0]  pulse_width_holding_reg;
    logic [7:0]  control_reg;
    logic [7:0]  control_next;
    logic [7:0]  width_pipe_reg [WIDTH_PIPE-1];
    logic [7:0]  count_reg;
    logic [7:0]  count_next;
    logic        half_reg;
    logic [1:0]  inh_sync_reg;
    run_state_t  run_reg;
    run_state_t  run_next;
    logic [7:0]  rdata_next;

    // Decoded wires
    ctl_t        ctl;
    logic        wr_width;
    logic        wr_control;
    logic        tick;
    logic        period_start;
    logic [7:0]  count_max;
    logic [7:0]  width_used;
    logic        cmp;
    logic        run_ok;
    logic [4:0]  dt_ticks;
    logic [4:0]  dt_prim;
    logic [4:0]  dt_comp;
    logic        tick_dly_reg;
    logic        full8;
    logic        prim_drive;
    logic        comp_drive;

    assign ctl = ctl_t'(control_reg);

    // Write decode
    assign wr_width   = REG_REQ.wr && (REG_REQ.addr == ADDR_WIDTH_REG);
    assign wr_control = REG_REQ.wr && (REG_REQ.addr == ADDR_CONTROL_REG);

    // Lock keeps every bit but stop; writes can never clear lock itself
    assign control_next = !wr_control ? control_reg :
                          ctl.lock ? {REG_REQ.wdata[CTL_RUN], control_reg[6:0]} :
                          REG_REQ.wdata;

    // Control and width latches; reset is the only initialiser
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            control_reg             <= CONTROL_RESET;
            pulse_width_holding_reg <= WIDTH_RESET;
        end else begin
            control_reg <= control_next;
            if (wr_width) begin
                pulse_width_holding_reg <= REG_REQ.wdata;
            end
        end
    end

    // Width delay line: latch load plus two stages gives three clocks to outputs
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            width_pipe_reg[0] <= WIDTH_RESET;
            width_pipe_reg[1] <= WIDTH_RESET;
        end else begin
            width_pipe_reg[0] <= pulse_width_holding_reg;
            width_pipe_reg[1] <= width_pipe_reg[0];
        end
    end

    // Counter clock: halving skips every other external clock
    assign tick      = ctl.halve ? half_reg : 1'b1;
    assign count_max = ctl.res8 ? 8'hFF : 8'h7F;
    assign count_next = (count_reg >= count_max) ? 8'h00 : count_reg + 8'h01;
    assign period_start = tick && (count_next == 8'h00);

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            half_reg     <= 1'b0;
            count_reg    <= 8'h00;
            tick_dly_reg <= 1'b0;
        end else begin
            half_reg     <= !half_reg;
            tick_dly_reg <= tick;
            if (tick) begin
                count_reg <= count_next;
            end
        end
    end

    // Compare against the live width so changes land mid-period; 7-bit uses the low bits,
    // and any value with bit 7 set in 7-bit mode means full on
    assign width_used = ctl.res8 ? width_pipe_reg[1] : (width_pipe_reg[1][7] ? 8'h80 : {1'b0, width_pipe_reg[1][6:0]});
    // In 8-bit mode the top code means full on, otherwise 100 percent is unreachable
    assign full8      = ctl.res8 && (width_pipe_reg[1] == 8'hFF);
    assign cmp        = full8 || ({1'b0, count_reg} < {1'b0, width_used});

    // Inhibit pin synchroniser
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            inh_sync_reg <= 2'b00;
        end else begin
            inh_sync_reg <= {inh_sync_reg[0], OUTPUT_ENABLE_N_INHIBIT};
        end
    end

    // Output gate: off at once, back on only at a period start with both enables high
    assign run_ok   = ctl.run && inh_sync_reg[1];
    assign run_next = !run_ok ? RUN_OFF : (period_start ? RUN_ON : run_reg);

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            run_reg <= RUN_OFF;
        end else begin
            case (run_reg)
                RUN_OFF: run_reg <= run_next;
                RUN_ON:  run_reg <= run_next;
                default: run_reg <= RUN_OFF;
            endcase
        end
    end

    // Dead-time in counter ticks; zero field means no blanking
    assign dt_ticks = 5'(ctl.deadtime_length_field) * 5'(DT_STEP_TICKS);
    // Blank only when the other side really turns off; one that never came on costs nothing
    assign dt_prim  = comp_drive ? dt_ticks : 5'h00;
    assign dt_comp  = prim_drive ? dt_ticks : 5'h00;

    // Each side blanks after its request rises, so a turn-off of one eats the other's
    // on-time; at 0 or 100 percent no request ever rises, hence no blanking
    dt_blanker #(.CW(5)) u_primary (
        .clock    (CLOCK),
        .rst      (RST),
        .tick     (tick_dly_reg),
        .dt_ticks (dt_prim),
        .req      (cmp),
        .enable   (!ctl.run ? 1'b0 : run_next == RUN_ON),
        .drive    (prim_drive)
    );

    dt_blanker #(.CW(5)) u_complementary (
        .clock    (CLOCK),
        .rst      (RST),
        .tick     (tick_dly_reg),
        .dt_ticks (dt_comp),
        .req      (!cmp),
        .enable   (!ctl.run ? 1'b0 : run_next == RUN_ON),
        .drive    (comp_drive)
    );

    assign PRIMARY_DRIVE_OUT       = prim_drive;
    assign COMPLEMENTARY_DRIVE_OUT = comp_drive;

    // Read side: width, control, and a live status word
    always_comb begin
        case (REG_REQ.addr)
            ADDR_WIDTH_REG:   rdata_next = pulse_width_holding_reg;
            ADDR_CONTROL_REG: rdata_next = control_reg;
            ADDR_STATUS_REG:  rdata_next = {5'h00, run_reg == RUN_ON, prim_drive, comp_drive};
            default:          rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            REG_RDATA <= 8'h00;
        end else begin
            REG_RDATA <= REG_REQ.rd ? rdata_next : 8'h00;
        end
    end
endmodule

// file: src/dtpwm_pkg.sv
// Purpose: Shared constants and types for the dead-time PWM generator
// Assumes: Register port with one-cycle read latency, 100 MHz CLOCK
// Notes:   Offsets are register indices on the plain register port
package dtpwm_pkg;

    // Register map
    localparam logic [1:0] ADDR_WIDTH_REG   = 2'h0;
    localparam logic [1:0] ADDR_CONTROL_REG = 2'h1;
    localparam logic [1:0] ADDR_STATUS_REG  = 2'h2;

    // Control latch field positions
    localparam int CTL_DT_LSB  = 0;
    localparam int CTL_DT_MSB  = 2;
    localparam int CTL_LOCK    = 4;
    localparam int CTL_HALVE   = 5;
    localparam int CTL_RES8    = 6;
    localparam int CTL_RUN     = 7;

    // Values after reset
    localparam logic [7:0] CONTROL_RESET = 8'h47;
    localparam logic [7:0] WIDTH_RESET   = 8'h00;

    // Counts
    localparam int DT_STEP_TICKS = 2;           // Dead-time ticks per field step, max 14 ticks
    localparam int WIDTH_PIPE    = 3;           // Cycles from latch load to outputs

    // Register port bundle
    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;

    // Decoded control latch
    typedef struct packed {
        logic       run;
        logic       res8;
        logic       halve;
        logic       lock;
        logic       reserved;               // Bit 3, unused, keeps the struct at the latch width
        logic [2:0] deadtime_length_field;
    } ctl_t;

endpackage

// file: src/dt_blanker.sv
// Purpose: Dead-time blanking for one output of the complementary pair
// Assumes: One call per output, tick marks each counter clock
// Notes:   Holds the output low for the dead-time after its drive request rises
`timescale 1ns/1ps
module dt_blanker #(
    parameter int CW = 5
) (
    // Clock and reset
    input  wire logic          clock,
    input  wire logic          rst,
    // Control
    input  wire logic          tick,
    input  wire logic [CW-1:0] dt_ticks,
    input  wire logic          req,
    input  wire logic          enable,
    // Result
    output logic               drive
);
    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    logic          prev_reg;
    logic          rise;
    logic          drive_next;

    // A rising request loads the delay; the on-time is eaten from its start
    assign rise       = req && !prev_reg;
    assign cnt_next   = !req ? '0 : (rise ? dt_ticks : ((tick && cnt_reg != '0) ? cnt_reg - 1'b1 : cnt_reg));
    // Short request ends before the delay so the output never turns on
    assign drive_next = enable && req && (cnt_next == '0);

    // Delay counter and output flop
    always_ff @(posedge clock) begin
        if (rst) begin
            cnt_reg  <= '0;
            prev_reg <= 1'b0;
            drive    <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            prev_reg <= req;
            drive    <= drive_next;
        end
    end
endmodule

// file: tb/dtpwm_chk.sv
// Purpose: Port assertions for the PWM core
// Assumes: Sees top ports only
// Notes:   Shadows rebuild control and width
`timescale 1ns/1ps
module dtpwm_chk (
    // Clock and reset
    input wire logic                CLOCK,
    input wire logic                RST,
    // Register port
    input wire dtpwm_pkg::reg_req_t REG_REQ,
    input wire logic [7:0]          REG_RDATA,
    // Inhibit and drives
    input wire logic                OUTPUT_ENABLE_N_INHIBIT,
    input wire logic                PRIMARY_DRIVE_OUT,
    input wire logic                COMPLEMENTARY_DRIVE_OUT
);
    import dtpwm_pkg::*;
    logic [7:0] ctl_reg, ctl_next, width_reg, width_next;
    wire        wr_c = REG_REQ.wr && (REG_REQ.addr == ADDR_CONTROL_REG);
    wire        wr_w = REG_REQ.wr && (REG_REQ.addr == ADDR_WIDTH_REG);
    // A locked write may only move the stop bit
    assign ctl_next   = !wr_c ? ctl_reg : (ctl_reg[CTL_LOCK] ? {REG_REQ.wdata[7], ctl_reg[6:0]} : REG_REQ.wdata);
    assign width_next = wr_w ? REG_REQ.wdata : width_reg;
    // Shadows
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            ctl_reg   <= CONTROL_RESET;
            width_reg <= WIDTH_RESET;
        end else begin
            ctl_reg   <= ctl_next;
            width_reg <= width_next;
        end
    end
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);
    // Steps that lead to a forced or steady output
    sequence s_stop; (!ctl_reg[CTL_RUN]) [*3]; endsequence
    sequence s_inh; (!OUTPUT_ENABLE_N_INHIBIT) [*4]; endsequence
    sequence s_full; (OUTPUT_ENABLE_N_INHIBIT && ctl_reg[CTL_RUN] && !ctl_reg[CTL_RES8] && width_reg[7]) [*3]; endsequence
    property p_ctl_rd; (REG_REQ.rd && REG_REQ.addr == ADDR_CONTROL_REG) |=> REG_RDATA == $past(ctl_reg); endproperty
    property p_w_rd; (REG_REQ.rd && REG_REQ.addr == ADDR_WIDTH_REG) |=> REG_RDATA == $past(width_reg); endproperty
    property p_idle; (!REG_REQ.rd || REG_REQ.addr == 2'h3) |=> REG_RDATA == 8'h00; endproperty
    property p_overlap; !(PRIMARY_DRIVE_OUT && COMPLEMENTARY_DRIVE_OUT); endproperty
    property p_stop; s_stop |-> !PRIMARY_DRIVE_OUT && !COMPLEMENTARY_DRIVE_OUT; endproperty
    property p_inh; s_inh |-> !PRIMARY_DRIVE_OUT && !COMPLEMENTARY_DRIVE_OUT; endproperty
    property p_full; s_full ##0 PRIMARY_DRIVE_OUT |=> PRIMARY_DRIVE_OUT; endproperty
    property p_zero; (ctl_reg[CTL_RUN] && width_reg == 8'h00) [*6] |-> !PRIMARY_DRIVE_OUT; endproperty
    a_ctl_rd: assert property (p_ctl_rd) else $error("control read mismatch");
    a_w_rd: assert property (p_w_rd) else $error("width read mismatch");
    a_idle: assert property (p_idle) else $error("read data not zero");
    a_overlap: assert property (p_overlap) else $error("both drives high");
    a_stop: assert property (p_stop) else $error("drive while stopped");
    a_inh: assert property (p_inh) else $error("drive while inhibited");
    a_full: assert property (p_full) else $error("full duty dropped");
    a_zero: assert property (p_zero) else $error("primary high at zero width");
endmodule
bind dtpwm_core dtpwm_chk u_chk (.CLOCK(CLOCK), .RST(RST), .REG_REQ(REG_REQ), .REG_RDATA(REG_RDATA),
    .OUTPUT_ENABLE_N_INHIBIT(OUTPUT_ENABLE_N_INHIBIT), .PRIMARY_DRIVE_OUT(PRIMARY_DRIVE_OUT),
    .COMPLEMENTARY_DRIVE_OUT(COMPLEMENTARY_DRIVE_OUT));

// file: tb/host_bus_model.sv
// Purpose: Processor model on the register port
// Assumes: Commands change just after a rising edge
// Notes:   Clamps values as careful firmware would
`timescale 1ns/1ps
module host_bus_model (
    // Commands
    input  wire logic [1:0]         cmd_addr,
    input  wire logic signed [31:0] cmd_value,
    input  wire logic               cmd_wr,
    input  wire logic               cmd_rd,
    // Register port
    output dtpwm_pkg::reg_req_t     req
);
    import dtpwm_pkg::*;
    logic [7:0] clamped;
    // Overflow would wrap to a wild duty, so saturate
    assign clamped = cmd_value < 0 ? 8'h00 : (cmd_value > 255 ? 8'hFF : cmd_value[7:0]);
    assign req     = '{addr: cmd_addr, wdata: clamped, wr: cmd_wr, rd: cmd_rd};
endmodule

// file: tb/test_deadtime_pwm_with_config_lock.sv
// Purpose: Self-checking bench for the PWM core
// Assumes: Processor model drives the register port
// Notes:   Duty is judged by high counts over one period
`timescale 1ns/1ps
module test_deadtime_pwm_with_config_lock;
    import dtpwm_pkg::*;
    logic               CLOCK, RST, inh, c_wr, c_rd, po, co;
    logic [1:0]         c_a;
    logic signed [31:0] c_v;
    logic [7:0]         rdata;
    reg_req_t           req;
    int                 err_count, compares, seed, i, v, we, per, mul, dt, hp, hc;
    int                 cycles = 0;
    int                 cw [7] = '{64, 128, 133, 32, 0, 5, 0};
    logic [7:0]         cc [7] = '{8'hC0, 8'hE0, 8'h80, 8'hA7, 8'hC7, 8'hC3, 8'hC0};
    host_bus_model host (.cmd_addr(c_a), .cmd_value(c_v), .cmd_wr(c_wr), .cmd_rd(c_rd), .req(req));
    dtpwm_core dut (.CLOCK(CLOCK), .RST(RST), .REG_REQ(req), .REG_RDATA(rdata), .OUTPUT_ENABLE_N_INHIBIT(inh),
        .PRIMARY_DRIVE_OUT(po), .COMPLEMENTARY_DRIVE_OUT(co));
    // Clock and hang guard
    initial begin
        CLOCK = 1'b0;
        forever #5 CLOCK = ~CLOCK;
    end
    always @(posedge CLOCK) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            err_count++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        compares++;
        if (s !== e) begin
            err_count++;
            $display("[FAIL] %s expected %0h seen %0h", n, e, s);
        end
    endtask
    // Bus cycles: one strobe cycle each
    task automatic wr(input logic [1:0] a, input int val);
        @(posedge CLOCK);
        c_a  <= a;
        c_v  <= val;
        c_wr <= 1'b1;
        @(posedge CLOCK);
        c_wr <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a, input logic [7:0] e);
        @(posedge CLOCK);
        c_a  <= a;
        c_rd <= 1'b1;
        @(posedge CLOCK);
        c_rd <= 1'b0;
        #1 chk("read data", {8'h00, rdata}, {8'h00, e});
    endtask
    // High time of one drive; blanking only when the other side really turns off
    function automatic int exp_on(int own, int oth);
        if (own <= dt) return 0;
        if (oth <= dt) return own * mul;
        return (own - dt) * mul;
    endfunction
    task automatic measure(input int n);
        hp = 0;
        hc = 0;
        repeat (n) begin
            @(posedge CLOCK);
            hp += po;
            hc += co;
        end
    endtask
    initial begin
        seed = 32'h044f;
        RST = 1'b1; inh = 1'b1; c_wr = 1'b0; c_rd = 1'b0; c_a = 2'h0; c_v = 0;
        err_count = 0;
        compares = 0;
        for (i = 0; i < 7; i++) begin
            @(posedge CLOCK);
            RST <= 1'b1;
            repeat (20) @(posedge CLOCK);
            RST <= 1'b0;
            if (i == 0) begin
                rd(ADDR_CONTROL_REG, CONTROL_RESET);
                rd(ADDR_WIDTH_REG, WIDTH_RESET);
                rd(2'h3, 8'h00);
                rd(ADDR_STATUS_REG, 8'h00);
            end
            if (i == 6) begin
                cw[6] = $random(seed) % 300;
                cc[6] = {5'h18, 3'($random(seed))};
            end
            wr(ADDR_WIDTH_REG, cw[i]);
            wr(ADDR_CONTROL_REG, cc[i]);
            v = cw[i] < 0 ? 0 : (cw[i] > 255 ? 255 : cw[i]);
            rd(ADDR_WIDTH_REG, v[7:0]);
            per = cc[i][CTL_RES8] ? 256 : 128;
            we = cc[i][CTL_RES8] ? (v == 255 ? 256 : v) : (v[7] ? 128 : v % 128);
            mul = cc[i][CTL_HALVE] ? 2 : 1;
            dt = DT_STEP_TICKS * int'(cc[i][2:0]);
            repeat (2 * per * mul + 8) @(posedge CLOCK);
            measure(per * mul);
            chk("primary high", hp[15:0], 16'(exp_on(we, per - we)));
            chk("complementary high", hc[15:0], 16'(exp_on(per - we, we)));
        end
        // Lock keeps all but the stop bit
        wr(ADDR_CONTROL_REG, 8'hD3);
        wr(ADDR_CONTROL_REG, 8'h20);
        rd(ADDR_CONTROL_REG, 8'h53);
        wr(ADDR_CONTROL_REG, 8'hA0);
        rd(ADDR_CONTROL_REG, 8'hD3);
        inh <= 1'b0;
        repeat (10) @(posedge CLOCK);
        chk("inhibited drives", {14'h0, po, co}, 16'h0);
        inh <= 1'b1;
        repeat (520) @(posedge CLOCK);
        per = 256;
        mul = 1;
        dt = 6;
        measure(256);
        chk("primary after inhibit", hp[15:0], 16'(exp_on(we, 256 - we)));
        wrap_up();
    end
endmodule
